// ==== rtl/rcsr_csum.sv ====
`timescale 1ns/10ps
`default_nettype none
module rcsr_csum
    import rcsr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       add,
    input  wire logic [7:0] data,
    output var  logic [7:0] sum,
    output var  logic       good
);
    // running 8-bit sum; wraps by design
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum <= 8'h00;
        end else if (clear) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= sum + data;
        end
    end

    // sum including the checksum byte must come to all ones
    assign good = (sum == CSUM_GOOD);
endmodule // rcsr_csum
`default_nettype wire

// ==== rtl/rcsr_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module rcsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // empty when the pointers match
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage has no reset, only the pointers and in_ready do
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            in_ready <= 1'b0;
        end else begin
            // room flag from the occupancy after this edge, so ready leaves a flop
            in_ready <= (AW+1)'(wr_ptr + push - rd_ptr - pop) != (AW+1)'(DEPTH);
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        (AW+1)'(wr_ptr - rd_ptr) <= (AW+1)'(DEPTH)) else $error("fifo holds more than its depth");
endmodule // rcsr_fifo
`default_nettype wire

// ==== rtl/rcsr_framer.sv ====
// How it works
// RULE1 - the host puts the known short address or 0xFFFE in the destination network address.
// RULE2 - option bit 0x01 suppresses the acknowledgement for that remote request.
// RULE3 - option bit 0x02 applies the setting at once, otherwise it waits for an apply command.
// RULE4 - option bit 0x40 selects the extended transmission timeout for the destination.
// RULE5 - the host drives all unsupported option bits to zero.
// RULE6 - parameter bytes after the command name mean a write, none mean a query.
// RULE7 - the checksum is 0xFF minus the low byte of the sum of bytes from offset 3 to before it.
// RULE8 - the two-byte length, high byte first, counts bytes between length and checksum.
// RULE9 - a frame of type 0x21 stores a source route to the destination.
// RULE10 - the host places zero in the request tag of a source route frame.
// RULE11 - the host supplies both destination addresses, taken from a route record indication.
// RULE12 - offsets 5 to 12 carry the 64-bit destination address, high byte first.
// RULE13 - a nonzero request tag asks for a correlated response, a zero tag for none.
// RULE14 - a source route frame with zero hops or more than forty is dropped silently.
// RULE15 - the host lists hops from the destination's neighbour toward the source.
// RULE16 - every frame starts with 0x7E, then length, type, fields and checksum.
// RULE17 - a frame with a bad checksum is discarded without effect.
`timescale 1ns/10ps
`default_nettype none
module rcsr_framer
    import rcsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic [63:0]      cmd_dst64,
    output logic [15:0]      cmd_dst16,
    output logic [15:0]      cmd_name,
    output logic [63:0]      cmd_param,
    output logic [3:0]       cmd_param_len,
    output logic             cmd_is_write,
    output logic             cmd_apply_now,
    output logic             cmd_no_ack,
    output logic             cmd_ext_timeout,
    output logic             cmd_respond,
    output logic [7:0]       cmd_tag,
    output logic             route_valid,
    output logic [63:0]      route_dst64,
    output logic [15:0]      route_dst16,
    output logic [7:0]       route_hops,
    output logic             route_dropped,
    output logic             csum_error
);
    // ************************************************************
    // reset release and input buffer
    // ************************************************************
    logic        rst_meta;
    logic        rst_sync_n;
    logic [7:0]  byte_d;
    logic        byte_v;
    logic        byte_take;

    // two-stage release so every flop leaves reset on the same edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // the fifo absorbs bursts while a finished command waits for its sink
    rcsr_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_sync_n),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (byte_d),
        .out_valid (byte_v),
        .out_ready (byte_take)
    );

    // ************************************************************
    // parser
    // ************************************************************
    rcsr_state_t state;
    logic [15:0] ofs;
    logic [15:0] len;
    logic [15:0] body_left;
    logic [7:0]  ftype;
    logic [7:0]  sum;
    logic        sum_good;
    logic        csum_clear;
    logic        csum_add;
    logic [7:0]  opts;
    logic [63:0] dst64;
    logic [15:0] dst16;
    logic [15:0] name;
    logic [63:0] param;
    logic [3:0]  plen;
    logic [7:0]  tag;
    logic [7:0]  hops;
    logic        accept;

    // hold bytes while a result waits for the command sink
    assign byte_take = byte_v && (state != ST_DONE);
    assign accept    = byte_take;
    assign csum_clear = accept && (state == ST_IDLE);
    assign csum_add   = accept && ((state == ST_BODY) || (state == ST_CSUM)); // RULE7

    rcsr_csum u_csum (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .clear (csum_clear),
        .add   (csum_add),
        .data  (byte_d),
        .sum   (sum),
        .good  (sum_good)
    );

    function automatic logic [63:0] shift_in(input logic [63:0] v, input logic [7:0] b);
        return {v[55:0], b};
    endfunction

    // frame walk: delimiter, length, body, checksum
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state     <= ST_IDLE;
            ofs       <= 16'h0000;
            len       <= 16'h0000;
            body_left <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept && byte_d == START_DELIM) begin // RULE16
                        state <= ST_LEN;
                        ofs   <= 16'h0001;
                    end
                end
                ST_LEN: begin
                    if (accept) begin
                        len <= {len[7:0], byte_d}; // RULE8
                        ofs <= ofs + 16'h0001;
                        if (ofs == 16'h0002) begin
                            body_left <= {len[7:0], byte_d};
                            state     <= ({len[7:0], byte_d} == 16'h0000) ? ST_CSUM : ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    if (accept) begin
                        ofs       <= ofs + 16'h0001;
                        body_left <= body_left - 16'h0001;
                        if (body_left == 16'h0001) begin
                            state <= ST_CSUM;
                        end
                    end
                end
                ST_CSUM: begin
                    if (accept) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!cmd_valid || cmd_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // field capture by offset
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ftype <= 8'h00;
            tag   <= 8'h00;
            dst64 <= 64'h0000_0000_0000_0000;
            dst16 <= 16'h0000;
            opts  <= 8'h00;
            name  <= 16'h0000;
            param <= 64'h0000_0000_0000_0000;
            plen  <= 4'h0;
            hops  <= 8'h00;
        end else if (accept && state == ST_LEN && ofs == 16'h0001) begin
            // a short frame must not act on the type and flags of the last one
            ftype <= 8'h00;
            tag   <= 8'h00;
            opts  <= 8'h00;
            hops  <= 8'h00;
            plen  <= 4'h0;
            param <= 64'h0000_0000_0000_0000;
        end else if (accept && state == ST_BODY) begin
            if (ofs == OFS_TYPE) begin
                ftype <= byte_d;
            end
            if (ofs == OFS_TAG) begin
                tag <= byte_d;
            end
            if (ofs >= OFS_DST64_FIRST && ofs <= OFS_DST64_LAST) begin
                dst64 <= shift_in(dst64, byte_d); // RULE12
            end
            if (ofs == OFS_DST16_MSB || ofs == OFS_DST16_LSB) begin
                dst16 <= {dst16[7:0], byte_d};
            end
            if (ofs == OFS_OPTIONS) begin
                opts <= byte_d;
            end
            if (ftype == TYPE_REMOTE_CMD && (ofs == OFS_CMD_HI || ofs == OFS_CMD_LO)) begin
                name <= {name[7:0], byte_d};
            end
            if (ftype == TYPE_SRC_ROUTE && ofs == OFS_HOPS) begin
                hops <= byte_d;
            end
            if (ftype == TYPE_REMOTE_CMD && ofs >= OFS_PARAM && plen < 4'(PARAM_MAX)) begin
                param <= shift_in(param, byte_d); // RULE6
                plen  <= plen + 4'h1;
            end
        end
    end

    // ************************************************************
    // results
    // ************************************************************
    logic frame_end;
    logic hop_ok;
    assign frame_end = accept && (state == ST_CSUM);
    assign hop_ok    = (hops != 8'h00) && (hops <= HOP_TABLE_MAX);

    // remote command out, held until the sink takes it
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmd_valid       <= 1'b0;
            cmd_dst64       <= 64'h0000_0000_0000_0000;
            cmd_dst16       <= 16'h0000;
            cmd_name        <= 16'h0000;
            cmd_param       <= 64'h0000_0000_0000_0000;
            cmd_param_len   <= 4'h0;
            cmd_is_write    <= 1'b0;
            cmd_apply_now   <= 1'b0;
            cmd_no_ack      <= 1'b0;
            cmd_ext_timeout <= 1'b0;
            cmd_respond     <= 1'b0;
            cmd_tag         <= 8'h00;
        end else if (frame_end && (sum + byte_d == CSUM_GOOD) && ftype == TYPE_REMOTE_CMD) begin // RULE17
            cmd_valid       <= 1'b1;
            cmd_dst64       <= dst64;
            cmd_dst16       <= dst16;
            cmd_name        <= name;
            cmd_param       <= param;
            cmd_param_len   <= plen;
            cmd_is_write    <= (plen != 4'h0); // RULE6
            cmd_apply_now   <= opts[OPT_APPLY_BIT]; // RULE3
            cmd_no_ack      <= opts[OPT_NO_ACK_BIT]; // RULE2
            cmd_ext_timeout <= opts[OPT_EXT_TO_BIT]; // RULE4
            cmd_respond     <= (tag != 8'h00) && !opts[OPT_NO_ACK_BIT]; // RULE13
            cmd_tag         <= tag;
        end else if (cmd_ready) begin
            cmd_valid <= 1'b0;
        end
    end

    // source route store and one-cycle status pulses
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            route_valid   <= 1'b0;
            route_dst64   <= 64'h0000_0000_0000_0000;
            route_dst16   <= 16'h0000;
            route_hops    <= 8'h00;
            route_dropped <= 1'b0;
            csum_error    <= 1'b0;
        end else begin
            route_valid   <= 1'b0;
            route_dropped <= 1'b0;
            csum_error    <= frame_end && (sum + byte_d != CSUM_GOOD); // RULE17
            if (frame_end && (sum + byte_d == CSUM_GOOD) && ftype == TYPE_SRC_ROUTE) begin
                if (hop_ok) begin // RULE14
                    route_valid <= 1'b1; // RULE9
                    route_dst64 <= dst64;
                    route_dst16 <= dst16;
                    route_hops  <= hops;
                end else begin
                    route_dropped <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_bad_sum_no_cmd: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (frame_end && (sum + byte_d != CSUM_GOOD) && !cmd_valid) |=> !cmd_valid) // RULE17
        else $error("command issued from bad checksum");
    chk_write_has_param: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cmd_valid |-> (cmd_is_write == (cmd_param_len != 4'h0))) // RULE6
        else $error("write flag disagrees with parameter count");
    chk_noack_no_resp: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (cmd_valid && cmd_no_ack) |-> !cmd_respond) // RULE2
        else $error("response asked despite ack suppression");
    chk_zero_tag_silent: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (cmd_valid && cmd_tag == 8'h00) |-> !cmd_respond) // RULE13
        else $error("response for zero tag");
    chk_route_hop_range: assert property (@(posedge clk) disable iff (!rst_sync_n)
        route_valid |-> (route_hops != 8'h00 && route_hops <= HOP_TABLE_MAX)) // RULE14
        else $error("route stored with illegal hop count");
    chk_route_after_sum: assert property (@(posedge clk) disable iff (!rst_sync_n)
        route_valid |-> $past(frame_end) && !csum_error) // RULE9
        else $error("route stored outside a frame end");
    chk_len_walk: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (state == ST_BODY && accept && body_left == 16'h0001) |=> state == ST_CSUM) // RULE8
        else $error("body length not honoured");
    chk_delim_start: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (state == ST_IDLE && accept) |=> ((state == ST_LEN) == ($past(byte_d) == START_DELIM))) // RULE16
        else $error("frame opened without delimiter");
    chk_sum_result: assert property (@(posedge clk) disable iff (!rst_sync_n)
        frame_end |=> (sum_good == !csum_error)) // RULE7
        else $error("checksum accumulator disagrees with error pulse");
    chk_opts_apply: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(cmd_valid) |-> cmd_apply_now == $past(opts[OPT_APPLY_BIT]) // RULE3
        && cmd_ext_timeout == $past(opts[OPT_EXT_TO_BIT])) // RULE4
        else $error("option bits not carried");

    cov_remote_write: cover property (@(posedge clk) disable iff (!rst_sync_n)
        cmd_valid && cmd_is_write);
    cov_remote_query: cover property (@(posedge clk) disable iff (!rst_sync_n)
        cmd_valid && !cmd_is_write);
    cov_route_stored: cover property (@(posedge clk) disable iff (!rst_sync_n) route_valid);
    cov_route_dropped: cover property (@(posedge clk) disable iff (!rst_sync_n) route_dropped);
    cov_sum_error: cover property (@(posedge clk) disable iff (!rst_sync_n) csum_error);
endmodule // rcsr_framer
`default_nettype wire

// ==== rtl/rcsr_pkg.sv ====
package rcsr_pkg;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam logic [7:0]  START_DELIM      = 8'h7E;
    localparam logic [7:0]  TYPE_REMOTE_CMD  = 8'h17;
    localparam logic [7:0]  TYPE_SRC_ROUTE   = 8'h21;
    localparam logic [7:0]  CSUM_GOOD        = 8'hFF;
    localparam logic [15:0] OFS_TYPE         = 16'h0003;
    localparam logic [15:0] OFS_TAG          = 16'h0004;
    localparam logic [15:0] OFS_DST64_FIRST  = 16'h0005;
    localparam logic [15:0] OFS_DST64_LAST   = 16'h000C;
    localparam logic [15:0] OFS_DST16_MSB    = 16'h000D;
    localparam logic [15:0] OFS_DST16_LSB    = 16'h000E;
    localparam logic [15:0] OFS_OPTIONS      = 16'h000F;
    localparam logic [15:0] OFS_CMD_HI       = 16'h0010;
    localparam logic [15:0] OFS_CMD_LO       = 16'h0011;
    localparam logic [15:0] OFS_PARAM        = 16'h0012;
    localparam logic [15:0] OFS_HOPS         = 16'h0010;
    localparam logic [15:0] OFS_HOP_FIRST    = 16'h0011;

    // ************************************************************
    // option bits and limits
    // ************************************************************
    localparam int          OPT_NO_ACK_BIT   = 0;
    localparam int          OPT_APPLY_BIT    = 1;
    localparam int          OPT_EXT_TO_BIT   = 6;
    localparam logic [7:0]  HOP_TABLE_MAX    = 8'd40;
    localparam logic [15:0] UNKNOWN_NET_ADDR = 16'hFFFE;
    localparam int          PARAM_MAX        = 8;
    localparam int          FIFO_WIDTH       = 8;
    localparam int          FIFO_DEPTH       = 16;

    // ************************************************************
    // parser states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LEN   = 5'b00010,
        ST_BODY  = 5'b00100,
        ST_CSUM  = 5'b01000,
        ST_DONE  = 5'b10000
    } rcsr_state_t;

endpackage

// ==== tb/rcsr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// host side: builds frames and offers them byte by byte
// ************************************************************
module rcsr_host_model (
    input  wire logic       clk,
    input  wire logic       rx_ready,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid
);
    int         gap = 0;   // idle cycles before each byte, models a slow host
    logic [7:0] body[$];

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end

    // released lines show the inverse of the last byte so nothing stale can match
    task automatic idle();
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    // ready only moves on a rising edge, so looking at it on the falling edge is race free
    task automatic put_byte(input logic [7:0] b);
        repeat (gap) idle();
        @(negedge clk);
        rx_data  = b;
        rx_valid = 1'b1;
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask

    // delimiter, length, body, checksum; corrupt flips the checksum low bit
    task automatic send_body(input logic corrupt);
        logic [7:0]  sum;
        logic [15:0] len;
        sum = 8'h00;
        len = 16'(body.size());
        put_byte(8'h7E);
        put_byte(len[15:8]);
        put_byte(len[7:0]);
        foreach (body[i]) begin
            put_byte(body[i]);
            sum = sum + body[i];
        end
        put_byte((8'hFF - sum) ^ {7'h00, corrupt});
        idle();
        body.delete();
    endtask

    task automatic cmd_frame(input logic [7:0] tag, input logic [63:0] dst64, input logic [15:0] dst16,
                             input logic [7:0] opts, input logic [15:0] name, input int n, input logic corrupt);
        body = {8'h17, tag};
        for (int i = 7; i >= 0; i--) body.push_back(dst64[i*8 +: 8]);
        body.push_back(dst16[15:8]);
        body.push_back(dst16[7:0]);
        body.push_back(opts & 8'h43);
        body.push_back(name[15:8]);
        body.push_back(name[7:0]);
        for (int i = 0; i < n; i++) body.push_back(8'h10 + 8'(i));
        send_body(corrupt);
    endtask

    task automatic route_frame(input logic [63:0] dst64, input logic [15:0] dst16, input int hops);
        body = {8'h21, 8'h00};
        for (int i = 7; i >= 0; i--) body.push_back(dst64[i*8 +: 8]);
        body.push_back(dst16[15:8]);
        body.push_back(dst16[7:0]);
        body.push_back(8'h00);
        body.push_back(8'(hops));
        for (int i = hops; i > 0; i--) begin
            body.push_back(8'hA0);
            body.push_back(8'(i));
        end
        send_body(1'b0);
    endtask
endmodule // rcsr_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [63:0] DST64 = 64'h1122_3344_5566_7788;
    logic clk, rst_n, rx_valid, rx_ready, cmd_valid, cmd_ready;
    logic [7:0] rx_data, cmd_tag, route_hops;
    logic [63:0] cmd_dst64, cmd_param, route_dst64;
    logic [15:0] cmd_dst16, cmd_name, route_dst16;
    logic [3:0] cmd_param_len;
    logic cmd_is_write, cmd_apply_now, cmd_no_ack, cmd_ext_timeout, cmd_respond;
    logic route_valid, route_dropped, csum_error;
    int errors, total_checks, cycles, route_n, drop_n, cerr_n;

    rcsr_host_model i_host (.clk(clk), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    rcsr_framer i_dut (
        .clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dst64(cmd_dst64), .cmd_dst16(cmd_dst16),
        .cmd_name(cmd_name), .cmd_param(cmd_param), .cmd_param_len(cmd_param_len),
        .cmd_is_write(cmd_is_write), .cmd_apply_now(cmd_apply_now), .cmd_no_ack(cmd_no_ack),
        .cmd_ext_timeout(cmd_ext_timeout), .cmd_respond(cmd_respond), .cmd_tag(cmd_tag),
        .route_valid(route_valid), .route_dst64(route_dst64), .route_dst16(route_dst16),
        .route_hops(route_hops), .route_dropped(route_dropped), .csum_error(csum_error)
    );

    // ************************************************************
    // clock, pulse monitors and hang guard
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // pulses are counted on the falling edge, where they are settled
    always @(negedge clk) begin
        route_n += int'(route_valid === 1'b1);
        drop_n  += int'(route_dropped === 1'b1);
        cerr_n  += int'(csum_error === 1'b1);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            conclude();
        end
    end

    // ************************************************************
    // checking and command tasks
    // ************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // waits for a command, compares every field, then takes it
    task automatic take_cmd(input logic [7:0] tag, input logic [7:0] opts, input int n);
        logic [63:0] par;
        int          w;
        par = 64'h0;
        w   = 0;
        for (int i = 0; i < n; i++) par = {par[55:0], 8'h10 + 8'(i)};
        @(negedge clk);
        while (cmd_valid !== 1'b1 && w < 200) begin
            @(negedge clk);
            w++;
        end
        chk(cmd_valid, 1, "cmd_valid");
        chk(cmd_dst64, DST64, "dst64");
        chk(cmd_dst16, 16'hFFFE, "dst16");
        chk(cmd_name, 16'h4248, "name");
        chk(cmd_param, par, "param");
        chk(cmd_param_len, n, "param_len");
        chk(cmd_is_write, n != 0, "is_write");
        chk(cmd_no_ack, opts[0], "no_ack");
        chk(cmd_apply_now, opts[1], "apply_now");
        chk(cmd_ext_timeout, opts[6], "ext_timeout");
        chk(cmd_tag, tag, "tag");
        chk(cmd_respond, tag != 0 && !opts[0], "respond");
        cmd_ready = 1'b1;
        @(negedge clk);
        cmd_ready = 1'b0;
    endtask

    // sends one route frame and checks stored or dropped
    task automatic route_test(input int hops, input logic ok);
        int r0, d0;
        r0 = route_n;
        d0 = drop_n;
        i_host.route_frame(DST64, 16'h3344, hops);
        repeat (10) @(negedge clk);
        chk(route_n - r0, ok, "route stored");
        chk(drop_n - d0, !ok, "route dropped");
        if (ok) begin
            chk(route_dst64, DST64, "route dst64");
            chk(route_dst16, 16'h3344, "route dst16");
            chk(route_hops, 8'(hops), "route hops");
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        logic [7:0] opt_tab[4] = '{8'h01, 8'h40, 8'h00, 8'h43};
        logic [7:0] tag_tab[4] = '{8'h05, 8'h00, 8'h07, 8'h09};
        int         n_tab[4]   = '{0, 8, 0, 2};
        rst_n     = 1'b0;
        cmd_ready = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        i_host.gap = 3;
        i_host.put_byte(8'h55);
        i_host.cmd_frame(8'h01, DST64, 16'hFFFE, 8'h02, 16'h4248, 1, 1'b0);
        take_cmd(8'h01, 8'h02, 1);
        chk(cmd_valid, 0, "cmd taken");
        $display("test slow write done");
        i_host.gap = 0;
        for (int k = 0; k < 4; k++) begin
            i_host.cmd_frame(tag_tab[k], DST64, 16'hFFFE, opt_tab[k], 16'h4248, n_tab[k], 1'b0);
            take_cmd(tag_tab[k], opt_tab[k], n_tab[k]);
        end
        $display("test options done");
        i_host.cmd_frame(8'h02, DST64, 16'hFFFE, 8'h02, 16'h4248, 1, 1'b1);
        repeat (20) @(negedge clk);
        chk(cerr_n, 1, "csum_error");
        chk(cmd_valid, 0, "bad frame ignored");
        $display("test bad checksum done");
        route_test(3, 1'b1);
        route_test(40, 1'b1);
        route_test(0, 1'b0);
        route_test(41, 1'b0);
        $display("test routes done");
        fork
            begin
                i_host.cmd_frame(8'h03, DST64, 16'hFFFE, 8'h00, 16'h4248, 1, 1'b0);
                i_host.cmd_frame(8'h04, DST64, 16'hFFFE, 8'h40, 16'h4248, 8, 1'b0);
            end
            begin
                repeat (60) @(negedge clk);
                chk(rx_ready, 0, "fifo full");
                take_cmd(8'h03, 8'h00, 1);
                take_cmd(8'h04, 8'h40, 8);
            end
        join
        $display("test back pressure done");
        conclude();
    end
endmodule // tb
`default_nettype wire
